// ---- rtl/mis_dev_end.sv ----
// two-processor interrupt controller: service registers, selection and scan-in
`timescale 1ns/1ps
// Operation
// RULE_01: four inter-processor channels, own vector and priority
// RULE_02: dispatch mask raises channel at each set cpu
// RULE_03: dispatch register shared, reachable at two addresses
// RULE_04: own bit in mask interrupts the writer
// RULE_05: software masks, polls activity, changes, unmasks
// RULE_06: activity flag holds while pending or serviced
// RULE_07: per-cpu eoi ends highest-priority in-service source
// RULE_08: after acknowledge only strictly higher priority presented
// RULE_09: software writes zero to end-of-interrupt register
// RULE_10: acknowledge read returns the signalled source vector
// RULE_11: reset mode passes input 0 to cpu0
// RULE_12: software switches to mixed mode at init; the engine writes it at base FEFF only, missing when the strap selects FEFE
// RULE_13: deliver only above the cpu task priority
// RULE_14: distributed delivery chooses by task priorities
// RULE_15: task priority changes may act late
// RULE_16: level source negated scan-length clocks before eoi
// RULE_17: external inputs scanned serially, change seen late
// RULE_18: registers on processor bus, any single-beat size
// RULE_19: base selectable between two fixed addresses
// RULE_20: write-one-set and write-one-clear fields, zeros ignored
// RULE_21: in-service record set on acknowledge, cleared on eoi
// RULE_22: reset task priority 15, priorities zero, masked
module mis_dev_end (
   // clock and reset
   input  wire logic MCLK_IN,
   input  wire logic RST_N_IN,
   // strap and serial interrupt inputs
   input  wire logic BASE_SEL_IN,
   input  wire logic EXT_SER_IN,
   input  wire logic EXT_FRAME_IN,
   // processor bus link
   mis_link_if.dev   lnk
);
   typedef struct packed {
      logic [2:0]                                ser_sy;
      logic                                      ser_f;
      logic [2:0]                                frm_sy;
      logic                                      frm_f;
      logic                                      frm_prev;
      logic [mis_pkg::NEXT-1:0]                  shf;
      logic [3:0]                                scnt;
      logic [mis_pkg::NEXT-1:0]                  lvl;
      logic                                      strap_done;
      logic                                      base_sel;
      logic                                      mixed;
      logic                                      spur;
      logic [mis_pkg::NSRC-1:0][7:0]             vec;
      logic [mis_pkg::NSRC-1:0][3:0]             pri;
      logic [mis_pkg::NSRC-1:0]                  msk;
      logic [mis_pkg::NEXT-1:0][1:0]             dst;
      logic [mis_pkg::NCPU-1:0][mis_pkg::NIPI-1:0] ipp;
      logic [mis_pkg::NCPU-1:0][3:0]             tp;
      logic [mis_pkg::NCPU-1:0][mis_pkg::NSRC-1:0] isv;
      logic [mis_pkg::NCPU-1:0][mis_pkg::SRCW-1:0] lsrc;
      logic [mis_pkg::NCPU-1:0]                  lvld;
      logic                                      ack;
      logic                                      err;
      logic [31:0]                               rdata;
      logic [1:0]                                irq;
   } mis_dev_st_t;

   mis_dev_st_t q_ff;
   mis_dev_st_t nxt_q;

   function automatic mis_pkg::mis_dec_t dec(input logic [15:0] off);
      mis_pkg::mis_dec_t d;
      logic [15:0]       r;
      d = '{kind: mis_pkg::K_NONE, idx: '0, cpu: 1'b0};
      r = '0;
      if (off == mis_pkg::OFF_CFG) begin
         d.kind = mis_pkg::K_CFG;
      end else if (off == mis_pkg::OFF_STAT) begin
         d.kind = mis_pkg::K_STAT;
      end else if (off[15:13] == mis_pkg::CPU_PAGE) begin
         d.cpu = off[12];
         if (off[11:0] >= mis_pkg::PG_DISP && off[11:0] < mis_pkg::PG_TASK && off[3:0] == 4'h0) begin
            d.kind = mis_pkg::K_DISP;
            r = {4'h0, off[11:0] - mis_pkg::PG_DISP};
            d.idx = r[8:4];
         end else if (off[11:0] == mis_pkg::PG_TASK) begin
            d.kind = mis_pkg::K_TASK;
         end else if (off[11:0] == mis_pkg::PG_ACK) begin
            d.kind = mis_pkg::K_ACK;
         end else if (off[11:0] == mis_pkg::PG_EOI) begin
            d.kind = mis_pkg::K_EOI;
         end
      end else if (off >= mis_pkg::OFF_IPIVP && off[3:0] == 4'h0
                   && off < mis_pkg::OFF_IPIVP + 16'(mis_pkg::NIPI) * mis_pkg::IPI_STRIDE) begin
         d.kind = mis_pkg::K_IPIVP;
         r = off - mis_pkg::OFF_IPIVP;
         d.idx = 5'(mis_pkg::NEXT) + r[8:4];
      end else if (off >= mis_pkg::OFF_SRCVP && off[3:0] == 4'h0
                   && off < mis_pkg::OFF_SRCVP + 16'(mis_pkg::NEXT) * mis_pkg::SRC_STRIDE) begin
         r = off - mis_pkg::OFF_SRCVP;
         d.kind = (r[4] == mis_pkg::OFF_SRCDST[4]) ? mis_pkg::K_SRCDST : mis_pkg::K_SRCVP;
         d.idx = r[9:5];
      end
      return d;
   endfunction : dec

   function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            m[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return m;
   endfunction : bmerge

   mis_pkg::mis_dec_t                    d;
   logic                                 hit;
   logic                                 take;
   logic [mis_pkg::NSRC-1:0]             act;
   logic [mis_pkg::NCPU-1:0]             sel_vld;
   logic [mis_pkg::NCPU-1:0][mis_pkg::SRCW-1:0] sel_src;
   logic [mis_pkg::NCPU-1:0][mis_pkg::SRCW-1:0] eoi_src;
   logic [mis_pkg::NCPU-1:0]             eoi_vld;
   logic [31:0]                          rdv;
   logic [31:0]                          wv;

   always_comb begin
      logic [3:0] bp;
      logic [3:0] hi;
      logic       pend;
      logic       oc;
      bp = '0;
      hi = '0;
      pend = 1'b0;
      oc = 1'b0;
      d = dec(lnk.addr[15:0]);
      hit = lnk.addr[31:16] == (q_ff.base_sel ? mis_pkg::BASE_HI_B : mis_pkg::BASE_HI_A); // RULE_19
      take = lnk.req & ~q_ff.ack; // RULE_18
      for (int s = 0; s < mis_pkg::NSRC; s++) begin
         act[s] = q_ff.isv[0][s] | q_ff.isv[1][s]; // RULE_06
         if (s < mis_pkg::NEXT) begin
            act[s] = act[s] | (q_ff.lvl[s] & ~q_ff.msk[s]);
         end else begin
            act[s] = act[s] | q_ff.ipp[0][s-mis_pkg::NEXT] | q_ff.ipp[1][s-mis_pkg::NEXT];
         end
      end
      for (int c = 0; c < mis_pkg::NCPU; c++) begin
         oc = (c == 0);
         hi = '0;
         eoi_vld[c] = 1'b0;
         eoi_src[c] = '0;
         for (int s = 0; s < mis_pkg::NSRC; s++) begin
            if (q_ff.isv[c][s] && (!eoi_vld[c] || q_ff.pri[s] > hi)) begin
               eoi_vld[c] = 1'b1; // RULE_07
               eoi_src[c] = 5'(s);
               hi = q_ff.pri[s];
            end
         end
         sel_vld[c] = 1'b0;
         sel_src[c] = '0;
         bp = '0;
         for (int s = 0; s < mis_pkg::NSRC; s++) begin
            if (s < mis_pkg::NEXT) begin
               if (q_ff.dst[s] == 2'b11) begin
                  // distributed: lower task priority wins, ties to cpu0
                  pend = (oc ? (q_ff.tp[0] <= q_ff.tp[1]) : (q_ff.tp[1] < q_ff.tp[0]))
                         & ~q_ff.isv[oc][s]; // RULE_14
               end else begin
                  pend = q_ff.dst[s][c];
               end
               pend = pend & q_ff.lvl[s] & ~q_ff.msk[s];
            end else begin
               pend = q_ff.ipp[c][s-mis_pkg::NEXT] & ~q_ff.msk[s]; // RULE_01
            end
            if (pend && q_ff.pri[s] > q_ff.tp[c] // RULE_13
                && (!eoi_vld[c] || q_ff.pri[s] > hi) // RULE_08
                && (!sel_vld[c] || q_ff.pri[s] > bp)) begin
               sel_vld[c] = 1'b1;
               sel_src[c] = 5'(s);
               bp = q_ff.pri[s];
            end
         end
      end
      rdv = '0;
      case (d.kind)
         mis_pkg::K_CFG: rdv[mis_pkg::CFG_MIXED_BIT] = q_ff.mixed;
         mis_pkg::K_STAT: rdv[mis_pkg::STAT_SPUR_BIT] = q_ff.spur;
         mis_pkg::K_IPIVP, mis_pkg::K_SRCVP: begin
            rdv[7:0] = q_ff.vec[d.idx];
            rdv[mis_pkg::VP_PRI_LSB +: 4] = q_ff.pri[d.idx];
            rdv[mis_pkg::VP_MASK_BIT] = q_ff.msk[d.idx];
            rdv[mis_pkg::VP_ACT_BIT] = act[d.idx];
         end
         mis_pkg::K_SRCDST: rdv[1:0] = q_ff.dst[d.idx[3:0]];
         mis_pkg::K_TASK: rdv[3:0] = q_ff.tp[d.cpu];
         mis_pkg::K_ACK: rdv[7:0] = q_ff.lvld[d.cpu] ? q_ff.vec[q_ff.lsrc[d.cpu]] : mis_pkg::SPUR_VEC; // RULE_10
         default: rdv = '0;
      endcase
      wv = bmerge(rdv, lnk.wdata, lnk.be);
   end

   always_comb begin
      logic ackc;
      ackc = 1'b0;
      nxt_q = q_ff;
      // three-stage pin sampling, a change counts once stages two and three agree
      nxt_q.ser_sy = {q_ff.ser_sy[1:0], EXT_SER_IN};
      nxt_q.frm_sy = {q_ff.frm_sy[1:0], EXT_FRAME_IN};
      if (q_ff.ser_sy[1] == q_ff.ser_sy[2]) begin
         nxt_q.ser_f = q_ff.ser_sy[2];
      end
      if (q_ff.frm_sy[1] == q_ff.frm_sy[2]) begin
         nxt_q.frm_f = q_ff.frm_sy[2];
      end
      nxt_q.frm_prev = q_ff.frm_f;
      // a level is seen only after a whole scan frame
      nxt_q.shf = {q_ff.ser_f, q_ff.shf[mis_pkg::NEXT-1:1]}; // RULE_17
      nxt_q.scnt = (q_ff.frm_f & ~q_ff.frm_prev) ? 4'h1 : q_ff.scnt + 4'h1;
      if (q_ff.scnt == mis_pkg::SCAN_LAST) begin
         nxt_q.lvl = nxt_q.shf;
      end
      // strap caught once after reset release
      if (!q_ff.strap_done) begin
         nxt_q.strap_done = 1'b1;
         nxt_q.base_sel = BASE_SEL_IN; // RULE_19
      end
      nxt_q.ack = take;
      nxt_q.err = take & (~hit | d.kind == mis_pkg::K_NONE);
      // writes and misses answer with a zero word so stale register contents never leak
      nxt_q.rdata = (take & hit & ~lnk.we) ? rdv : '0;
      if (take && hit && lnk.we) begin
         case (d.kind)
            mis_pkg::K_CFG: nxt_q.mixed = wv[mis_pkg::CFG_MIXED_BIT];
            mis_pkg::K_STAT: if (lnk.be[0] && lnk.wdata[mis_pkg::STAT_SPUR_BIT]) nxt_q.spur = 1'b0; // RULE_20
            mis_pkg::K_IPIVP, mis_pkg::K_SRCVP: begin
               nxt_q.vec[d.idx] = wv[7:0];
               nxt_q.pri[d.idx] = wv[mis_pkg::VP_PRI_LSB +: 4];
               nxt_q.msk[d.idx] = wv[mis_pkg::VP_MASK_BIT];
            end
            mis_pkg::K_SRCDST: nxt_q.dst[d.idx[3:0]] = wv[1:0];
            mis_pkg::K_DISP: begin
               // either page's copy reaches the one channel; zero bits leave pending alone
               for (int c = 0; c < mis_pkg::NCPU; c++) begin
                  if (lnk.be[0] && lnk.wdata[c]) nxt_q.ipp[c][d.idx[1:0]] = 1'b1; // RULE_02 RULE_03 RULE_04 RULE_20
               end
            end
            mis_pkg::K_TASK: nxt_q.tp[d.cpu] = wv[3:0]; // RULE_15
            mis_pkg::K_EOI: if (eoi_vld[d.cpu]) nxt_q.isv[d.cpu][eoi_src[d.cpu]] = 1'b0; // RULE_07 RULE_21
            default: nxt_q.mixed = q_ff.mixed;
         endcase
      end
      if (take && hit && !lnk.we && d.kind == mis_pkg::K_ACK) begin
         ackc = 1'b1;
         if (q_ff.lvld[d.cpu]) begin
            nxt_q.isv[d.cpu][q_ff.lsrc[d.cpu]] = 1'b1; // RULE_21
            if (q_ff.lsrc[d.cpu] >= 5'(mis_pkg::NEXT)) begin
               nxt_q.ipp[d.cpu][2'(q_ff.lsrc[d.cpu] - 5'(mis_pkg::NEXT))] = 1'b0;
            end
         end else begin
            nxt_q.spur = 1'b1; // set wins over the clear above
         end
      end
      // the latch holds still while its vector is being read
      for (int c = 0; c < mis_pkg::NCPU; c++) begin
         if (!(ackc && d.cpu == c[0])) begin
            nxt_q.lvld[c] = sel_vld[c];
            nxt_q.lsrc[c] = sel_src[c];
         end
      end
      nxt_q.irq[0] = q_ff.mixed ? q_ff.lvld[0] : q_ff.lvl[0]; // RULE_11
      nxt_q.irq[1] = q_ff.mixed & q_ff.lvld[1];
   end

   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         q_ff <= '0;
         q_ff.tp <= {mis_pkg::NCPU{mis_pkg::TASK_RST}}; // RULE_22
         q_ff.msk <= '1;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign lnk.ack = q_ff.ack;
   assign lnk.err = q_ff.err;
   assign lnk.rdata = q_ff.rdata;
   assign lnk.irq = q_ff.irq;
endmodule : mis_dev_end

// ---- shared/mis_pkg.sv ----
// constants and types shared by both ends of the interrupt service link
package mis_pkg;
   localparam int NCPU = 2;
   localparam int NIPI = 4;
   localparam int NEXT = 16;
   localparam int NSRC = 20;
   localparam int SRCW = 5;
   // register block base, strap selected
   localparam logic [15:0] BASE_HI_A = 16'hFEFF;
   localparam logic [15:0] BASE_HI_B = 16'hFEFE;
   // controller offsets from the base
   localparam logic [15:0] OFF_CFG    = 16'h0020;
   localparam logic [15:0] OFF_STAT   = 16'h0024;
   localparam logic [15:0] OFF_IPIVP  = 16'h00A0;
   localparam logic [15:0] IPI_STRIDE = 16'h0010;
   localparam logic [15:0] OFF_SRCVP  = 16'h0400;
   localparam logic [15:0] OFF_SRCDST = 16'h0010;
   localparam logic [15:0] SRC_STRIDE = 16'h0020;
   localparam logic [2:0]  CPU_PAGE   = 3'h1;
   localparam logic [11:0] PG_DISP    = 12'h040;
   localparam logic [11:0] PG_TASK    = 12'h080;
   localparam logic [11:0] PG_ACK     = 12'h0A0;
   localparam logic [11:0] PG_EOI     = 12'h0B0;
   // field positions
   localparam int VP_MASK_BIT   = 31;
   localparam int VP_ACT_BIT    = 30;
   localparam int VP_PRI_LSB    = 16;
   localparam int CFG_MIXED_BIT = 0;
   localparam int STAT_SPUR_BIT = 0;
   // reset task priority, spurious vector and scan timing
   localparam logic [3:0] TASK_RST = 4'hF;
   localparam logic [7:0] SPUR_VEC = 8'hFF;
   localparam logic [3:0] SCAN_LAST = 4'hF;
   localparam logic [4:0] SCAN_CLOCKS = 5'h10;
   // command engine registers on the apb side
   localparam logic [11:0] H_ADDR  = 12'h000;
   localparam logic [11:0] H_WDATA = 12'h004;
   localparam logic [11:0] H_CTRL  = 12'h008;
   localparam logic [11:0] H_STAT  = 12'h00C;
   localparam logic [11:0] H_RDATA = 12'h010;
   localparam int CT_GO = 0;
   localparam int CT_WE = 1;
   localparam int CT_OP_LSB = 4;
   localparam int CT_BE_LSB = 8;
   localparam int HS_BUSY = 0;
   localparam int HS_DONE = 1;
   localparam int HS_ERR = 2;
   localparam int HS_IRQ_LSB = 4;
   typedef enum logic [1:0] {OP_PLAIN, OP_EOI, OP_RECFG, OP_RSVD} mis_op_t;
   typedef enum logic [3:0] {K_NONE, K_CFG, K_STAT, K_IPIVP, K_DISP, K_SRCVP, K_SRCDST,
                             K_TASK, K_ACK, K_EOI} mis_kind_t;
   typedef struct packed {
      mis_kind_t        kind;
      logic [SRCW-1:0]  idx;
      logic             cpu;
   } mis_dec_t;
endpackage : mis_pkg

// ---- shared/mis_link_if.sv ----
// processor bus link between the processors' command engine and the controller
`timescale 1ns/1ps
interface mis_link_if (
   input wire logic clk,
   input wire logic rst_n
);
   logic        req;
   logic        we;
   logic [31:0] addr;
   logic [3:0]  be;
   logic [31:0] wdata;
   logic        ack;
   logic        err;
   logic [31:0] rdata;
   logic [1:0]  irq;
   modport dev (input req, we, addr, be, wdata, output ack, err, rdata, irq);
   modport host (output req, we, addr, be, wdata, input ack, err, rdata, irq);
endinterface : mis_link_if

// ---- rtl/mis_host_end.sv ----
// processor-side command engine: apb registers driving the controller link
`timescale 1ns/1ps
module mis_host_end (
   // clock and reset
   input  wire logic        MCLK_IN,
   input  wire logic        RST_N_IN,
   // apb slave
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [11:0] PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   output logic             PREADY_OUT,
   output logic [31:0]      PRDATA_OUT,
   output logic             PSLVERR_OUT,
   // interrupt lines seen by the processors
   output logic [1:0]       CPU_IRQ_OUT,
   // processor bus link
   mis_link_if.host         lnk
);
   typedef enum {H_INIT, H_IDLE, H_DELAY, H_XFER, H_NEXT} mis_hst_t;
   typedef struct packed {
      mis_hst_t        st;
      mis_pkg::mis_op_t op;
      logic [2:0]      step;
      logic [4:0]      dly;
      logic [31:0]     c_addr;
      logic [31:0]     c_wdata;
      logic            c_we;
      logic [3:0]      c_be;
      logic [31:0]     rd;
      logic            busy;
      logic            done;
      logic            err;
      logic            req;
      logic            we;
      logic [31:0]     addr;
      logic [3:0]      be;
      logic [31:0]     wdata;
      logic            pready;
      logic            pslverr;
      logic [31:0]     prdata;
      logic [1:0]      irq;
   } mis_host_st_t;

   mis_host_st_t q_ff;
   mis_host_st_t nxt_q;

   always_comb begin
      logic        fin;
      logic        iss;
      logic [31:0] sv;
      fin = 1'b0;
      iss = 1'b0;
      sv = '0;
      nxt_q = q_ff;
      nxt_q.irq = lnk.irq;
      nxt_q.pready = PSEL_IN & PENABLE_IN & ~q_ff.pready;
      nxt_q.pslverr = 1'b0;
      case (q_ff.st)
         H_INIT: begin
            nxt_q.we = 1'b1;
            nxt_q.addr = {mis_pkg::BASE_HI_A, mis_pkg::OFF_CFG};
            nxt_q.be = '1;
            nxt_q.wdata = 32'h0000_0001 << mis_pkg::CFG_MIXED_BIT; // RULE_12
            nxt_q.op = mis_pkg::OP_PLAIN;
            nxt_q.req = 1'b1;
            nxt_q.busy = 1'b1;
            nxt_q.st = H_XFER;
         end
         H_DELAY: begin
            // let the scan chain see the level fall before ending service
            nxt_q.dly = q_ff.dly + 5'h01;
            if (q_ff.dly == mis_pkg::SCAN_CLOCKS) begin // RULE_16
               nxt_q.we = 1'b1;
               nxt_q.addr = q_ff.c_addr;
               nxt_q.be = '1;
               nxt_q.wdata = '0; // RULE_09
               nxt_q.req = 1'b1;
               nxt_q.st = H_XFER;
            end
         end
         H_XFER: begin
            if (lnk.ack) begin
               nxt_q.req = 1'b0;
               nxt_q.rd = lnk.rdata;
               nxt_q.err = q_ff.err | lnk.err;
               nxt_q.st = H_NEXT;
            end
         end
         H_NEXT: begin
            if (q_ff.op == mis_pkg::OP_RECFG) begin
               // mask, wait for the activity flag to drop, change, unmask
               iss = 1'b1; // RULE_05
               nxt_q.we = 1'b1;
               nxt_q.step = q_ff.step + 3'h1;
               case (q_ff.step)
                  3'h0: nxt_q.wdata = q_ff.rd | (32'h0000_0001 << mis_pkg::VP_MASK_BIT);
                  3'h1: nxt_q.we = 1'b0;
                  3'h2: begin
                     nxt_q.wdata = q_ff.c_wdata | (32'h0000_0001 << mis_pkg::VP_MASK_BIT);
                     if (q_ff.rd[mis_pkg::VP_ACT_BIT]) begin
                        nxt_q.we = 1'b0;
                        nxt_q.step = q_ff.step;
                     end
                  end
                  3'h3: nxt_q.wdata = q_ff.c_wdata & ~(32'h0000_0001 << mis_pkg::VP_MASK_BIT);
                  default: begin
                     iss = 1'b0;
                     fin = 1'b1;
                  end
               endcase
               nxt_q.req = iss;
               nxt_q.st = iss ? H_XFER : H_IDLE;
            end else begin
               fin = 1'b1;
               nxt_q.st = H_IDLE;
            end
         end
         default: nxt_q.st = H_IDLE;
      endcase
      if (PSEL_IN && PENABLE_IN && !q_ff.pready) begin
         if (PADDR_IN == mis_pkg::H_ADDR) begin
            sv = q_ff.c_addr;
            if (PWRITE_IN) nxt_q.c_addr = PWDATA_IN;
         end else if (PADDR_IN == mis_pkg::H_WDATA) begin
            sv = q_ff.c_wdata;
            if (PWRITE_IN) nxt_q.c_wdata = PWDATA_IN;
         end else if (PADDR_IN == mis_pkg::H_CTRL) begin
            sv[mis_pkg::CT_WE] = q_ff.c_we;
            sv[mis_pkg::CT_OP_LSB +: 2] = q_ff.op;
            sv[mis_pkg::CT_BE_LSB +: 4] = q_ff.c_be;
            if (PWRITE_IN && !q_ff.busy) begin
               nxt_q.c_we = PWDATA_IN[mis_pkg::CT_WE];
               nxt_q.op = mis_pkg::mis_op_t'(PWDATA_IN[mis_pkg::CT_OP_LSB +: 2]);
               nxt_q.c_be = PWDATA_IN[mis_pkg::CT_BE_LSB +: 4];
               if (PWDATA_IN[mis_pkg::CT_GO]) begin
                  nxt_q.busy = 1'b1;
                  nxt_q.err = 1'b0;
                  nxt_q.step = '0;
                  nxt_q.dly = '0;
                  nxt_q.addr = q_ff.c_addr;
                  nxt_q.we = PWDATA_IN[mis_pkg::CT_WE];
                  nxt_q.be = PWDATA_IN[mis_pkg::CT_BE_LSB +: 4];
                  nxt_q.wdata = q_ff.c_wdata;
                  case (mis_pkg::mis_op_t'(PWDATA_IN[mis_pkg::CT_OP_LSB +: 2]))
                     mis_pkg::OP_EOI: nxt_q.st = H_DELAY;
                     mis_pkg::OP_RECFG: begin
                        nxt_q.we = 1'b0;
                        nxt_q.be = '1;
                        nxt_q.req = 1'b1;
                        nxt_q.st = H_XFER;
                     end
                     default: begin
                        nxt_q.req = 1'b1;
                        nxt_q.st = H_XFER;
                     end
                  endcase
               end
            end
         end else if (PADDR_IN == mis_pkg::H_STAT) begin
            sv[mis_pkg::HS_BUSY] = q_ff.busy;
            sv[mis_pkg::HS_DONE] = q_ff.done;
            sv[mis_pkg::HS_ERR] = q_ff.err;
            sv[mis_pkg::HS_IRQ_LSB +: 2] = q_ff.irq;
            if (PWRITE_IN && PWDATA_IN[mis_pkg::HS_DONE]) nxt_q.done = 1'b0;
         end else if (PADDR_IN == mis_pkg::H_RDATA) begin
            sv = q_ff.rd;
         end else begin
            nxt_q.pslverr = 1'b1;
         end
      end
      nxt_q.prdata = sv;
      if (fin) begin
         nxt_q.busy = 1'b0;
         nxt_q.done = 1'b1;
      end
   end

   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         q_ff <= '0;
         q_ff.st <= H_INIT;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign lnk.req = q_ff.req;
   assign lnk.we = q_ff.we;
   assign lnk.addr = q_ff.addr;
   assign lnk.be = q_ff.be;
   assign lnk.wdata = q_ff.wdata;
   assign PREADY_OUT = q_ff.pready;
   assign PRDATA_OUT = q_ff.prdata;
   assign PSLVERR_OUT = q_ff.pslverr;
   assign CPU_IRQ_OUT = q_ff.irq;
endmodule : mis_host_end

// ---- dv/mis_link_sva.sv ----
// protocol checker on the link between the command engine and the controller
`timescale 1ns/1ps
module mis_link_sva (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        req,
   input wire logic        we,
   input wire logic [31:0] addr,
   input wire logic [3:0]  be,
   input wire logic [31:0] wdata,
   input wire logic        ack,
   input wire logic        err,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ack_one_cycle: assert property (ack |=> !ack) else $error("ack held too long");
   a_ack_has_cause: assert property (ack |-> $past(req)) else $error("ack without request");
   a_ack_next_edge: assert property (req && !ack |=> ack) else $error("ack late");
   a_req_held: assert property (req && !ack |=> req && $stable({we, addr, be, wdata})) else $error("request moved");
   a_req_drops: assert property (ack |=> !req) else $error("request kept after ack");
   a_req_gap: assert property ($rose(req) |-> !ack && !$past(ack)) else $error("request too soon");
   a_err_with_ack: assert property (err |-> ack) else $error("err outside ack");
   a_rdata_quiet: assert property (ack && (we || err) |-> rdata == 32'h0000_0000) else $error("rdata on write");
   c_err: cover property (ack && err);
   c_vec_read: cover property (ack && !we && rdata[7:0] != 8'hFF);
   c_irq_cpu1: cover property ($rose(irq[1]));
endmodule : mis_link_sva

// ---- dv/mp_interrupt_service_logic_test.sv ----
// scenario bench driving both ends of the interrupt service link over apb
`timescale 1ns/1ps
module mp_interrupt_service_logic_test;
   logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, e;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, r, st;
   logic [1:0]  irq;
   int          err_count = 0, samples_checked = 0;
   mis_link_if lnk (.clk(clk), .rst_n(rst_n));
   mis_dev_end mis_dev_end_inst (.MCLK_IN(clk), .RST_N_IN(rst_n), .BASE_SEL_IN(1'b0), .EXT_SER_IN(1'b0),
      .EXT_FRAME_IN(1'b0), .lnk(lnk.dev));
   mis_host_end mis_host_end_inst (.MCLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PREADY_OUT(pready), .PRDATA_OUT(prdata),
      .PSLVERR_OUT(pslverr), .CPU_IRQ_OUT(irq), .lnk(lnk.host));
   mis_link_sva mis_link_sva_inst (.clk(clk), .rst_n(rst_n), .req(lnk.req), .we(lnk.we), .addr(lnk.addr),
      .be(lnk.be), .wdata(lnk.wdata), .ack(lnk.ack), .err(lnk.err), .rdata(lnk.rdata), .irq(lnk.irq));
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic close_out;
      if (err_count == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // bounded wait; a hang ends the run here
   task automatic limit(input int n);
      if (n >= 200) begin
         chk(32'h0000_0000, 32'h0000_0001);
         close_out();
      end
   endtask : limit
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      // request held until the edge that samples pready high; data taken at that edge
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 200);
      limit(pready === 1'b1 ? 0 : n);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   // one link command with op o through the command engine, full byte enables
   task automatic lk(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [1:0] o);
      int n;
      apb(1'b1, mis_pkg::H_ADDR, a);
      apb(1'b1, mis_pkg::H_WDATA, d);
      apb(1'b1, mis_pkg::H_CTRL, {20'h0_0000, 4'hF, 2'h0, o, 2'h0, w, 1'h1});
      for (n = 0; n < 200 && (n == 0 || r[mis_pkg::HS_BUSY] !== 1'b0); n++) apb(1'b0, mis_pkg::H_STAT, 32'h0000_0000);
      limit(n);
      st = r;
      apb(1'b0, mis_pkg::H_RDATA, 32'h0000_0000);
   endtask : lk
   task automatic wirq(input int i, input logic v);
      int n;
      for (n = 0; n < 200 && irq[i] !== v; n++) @(negedge clk);
      limit(n);
   endtask : wirq
   task automatic s_reset;
      lk(1'b0, 32'hFEFF_2080, 32'h0000_0000, 2'h0);
      chk(r, 32'h0000_000F);
      lk(1'b0, 32'hFEFF_0400, 32'h0000_0000, 2'h0);
      chk({16'h0000, r[31:16]}, 32'h0000_8000);
   endtask : s_reset
   // dispatch written through cpu1's page must reach the target, cpu0 or cpu1
   task automatic s_ipi(input int c, input logic [31:0] pg, input logic [31:0] disp);
      // the channel's own vector word sits at the slot that matches the dispatch slot
      lk(1'b1, 32'hFEFF_00A0 + (disp & 32'h0000_0030), 32'h0005_0042, 2'h0);
      lk(1'b1, disp, 32'h0000_0001 << c, 2'h0);
      repeat (30) @(negedge clk);
      chk({31'h0, irq[c]}, 32'h0000_0000);
      lk(1'b1, pg + 32'h0000_0080, 32'h0000_0004, 2'h0);
      wirq(c, 1'b1);
      lk(1'b0, pg + 32'h0000_00A0, 32'h0000_0000, 2'h0);
      chk(r, 32'h0000_0042);
      wirq(c, 1'b0);
      lk(1'b1, pg + 32'h0000_00B0, 32'h0000_0000, mis_pkg::OP_EOI);
      lk(1'b0, pg + 32'h0000_00A0, 32'h0000_0000, 2'h0);
      chk(r, 32'h0000_00FF);
   endtask : s_ipi
   task automatic s_base;
      lk(1'b1, 32'hFEFE_0020, 32'h0000_0000, 2'h0);
      chk({31'h0, st[mis_pkg::HS_ERR]}, 32'h0000_0001);
      apb(1'b0, 12'h014, 32'h0000_0000);
      chk({31'h0, e}, 32'h0000_0001);
   endtask : s_base
   // source reconfigured through mask, poll activity, change, unmask
   task automatic s_recfg;
      lk(1'b1, 32'hFEFF_0420, 32'h0003_0011, mis_pkg::OP_RECFG);
      lk(1'b0, 32'hFEFF_0420, 32'h0000_0000, 2'h0);
      chk(r, 32'h0003_0011);
   endtask : s_recfg
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      s_reset();
      s_ipi(0, 32'hFEFF_2000, 32'hFEFF_3040);
      s_ipi(1, 32'hFEFF_3000, 32'hFEFF_3050);
      s_base();
      s_recfg();
      close_out();
   end
endmodule : mp_interrupt_service_logic_test
